/* hw/gpd_pkg.sv */
// gpd_pkg: constants, register map and carrier types of the gpio port block
// assumes: every port instance and its helper modules refer to it as gpd_pkg::name
package gpd_pkg;

    // ------------------------------------------------------------------
    // port geometry
    // ------------------------------------------------------------------
    localparam int PIN_COUNT = 12;          // pin bits 11..0 of every register
    localparam int ADDR_W = 32;
    localparam int DATA_W = 32;
    localparam int HALF_W = 16;
    localparam int OFFS_W = 16;             // offset inside one 64 KB port window
    localparam int MASK_LSB = 2;            // address bit 2 enables pin bit 0

    // ------------------------------------------------------------------
    // port windows: port n sits at first base plus n times the stride
    // ------------------------------------------------------------------
    localparam logic [ADDR_W-1:0] PORT_BASE0 = 32'h5000_0000;
    localparam logic [ADDR_W-1:0] PORT_STRIDE = 32'h0001_0000;

    // ------------------------------------------------------------------
    // register offsets within a port window
    // ------------------------------------------------------------------
    localparam logic [OFFS_W-1:0] OFS_PIN_VALUE_LAST = 16'h3ffc; // full, unmasked access
    localparam logic [OFFS_W-1:0] OFS_PIN_VALUE_END = 16'h4000;  // first offset past window
    localparam logic [OFFS_W-1:0] OFS_PIN_DIRECTION = 16'h8000;
    localparam logic [OFFS_W-1:0] OFS_IRQ_SENSE_SELECT = 16'h8004;
    localparam logic [OFFS_W-1:0] OFS_IRQ_DUAL_EDGE = 16'h8008;
    localparam logic [OFFS_W-1:0] OFS_IRQ_POLARITY = 16'h800c;
    localparam logic [OFFS_W-1:0] OFS_IRQ_MASK = 16'h8010;
    localparam logic [OFFS_W-1:0] OFS_IRQ_RAW_FLAGS = 16'h8014;
    localparam logic [OFFS_W-1:0] OFS_IRQ_MASKED_FLAGS = 16'h8018;
    localparam logic [OFFS_W-1:0] OFS_IRQ_EDGE_CLEAR = 16'h801c;

    // ------------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------------
    localparam logic [PIN_COUNT-1:0] RST_PINS = 12'h000;
    localparam logic [DATA_W-1:0] RST_WORD = 32'h0000_0000;

    // ------------------------------------------------------------------
    // carrier of one bus request
    // ------------------------------------------------------------------
    typedef struct packed {
        logic sel;                          // request valid this cycle
        logic write;                        // 1 write, 0 read
        logic half;                         // 1 half-word, 0 word
        logic [ADDR_W-1:0] addr;            // byte address, word aligned
        logic [DATA_W-1:0] wdata;
    } gpd_bus_req_t;

    // per-pin interrupt configuration bundle
    typedef struct packed {
        logic sense;                        // 0 edge, 1 level
        logic dual;                         // 1 both edges
        logic pol;                          // 0 falling or low, 1 rising or high
    } gpd_irq_cfg_t;

endpackage

/* hw/gpd_sync2.sv */
// gpd_sync2: two-stage synchroniser for a vector of pin levels
// assumes: inputs are asynchronous to ref_clk; only stage two is read outside
`timescale 1ns/100ps
module gpd_sync2 #(
    parameter int WIDTH = 12
)(
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic clk_en,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta_r;

    // two flops in series; stage one feeds stage two only
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            meta_r <= '0;
            sync_out <= '0;
        end
        else if (clk_en)
        begin
            meta_r <= async_in;
            sync_out <= meta_r;
        end
    end

endmodule

/* hw/gpd_irq_cell.sv */
// gpd_irq_cell: edge or level trigger detection for one pin
// assumes: level input is already synchronised to ref_clk
`timescale 1ns/100ps
module gpd_irq_cell (
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic clk_en,
    input wire logic level,
    input wire gpd_pkg::gpd_irq_cfg_t cfg,
    input wire logic edge_clear,
    output logic raw_flag
);

    logic prev_r;
    logic rise;
    logic fall;
    logic edge_hit;
    logic level_hit;

    // edge and level conditions
    assign rise = level & ~prev_r;
    assign fall = ~level & prev_r;
    assign edge_hit = cfg.dual ? (rise | fall) : (cfg.pol ? rise : fall);
    assign level_hit = cfg.pol ? level : ~level;

    // previous level for edge detection
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
            prev_r <= 1'b0;
        else if (clk_en)
            prev_r <= level;
    end

    // flag: follows level in level mode, sticky in edge mode, set beats clear
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
            raw_flag <= 1'b0;
        else if (clk_en)
        begin
            if (cfg.sense)
                raw_flag <= level_hit;
            else if (edge_hit)
                raw_flag <= 1'b1;
            else if (edge_clear)
                raw_flag <= 1'b0;
        end
    end

endmodule

/* hw/gpd_port.sv */
// gpd_port: one general-purpose i/o port of up to twelve pins with its registers
// assumes: one processor bus request per cycle at most, word-aligned addresses;
// alternate-function select, drive and enable come from logic on ref_clk;
// pin levels arrive asynchronously from the pads.
//
// Function
// - every register holds one bit per pin in bits 11..0; absent pins reserved
// - direction bits clear at reset, all pins start as inputs
// - direction bit 0 makes pin an input, 1 an output
// - registers up to 12 bits, word and half-word access at word addresses
// - pin value accesses below 0x4000 are masked by address bits 13..2
// - top offset of the masking window reaches all twelve pin bits
// - pin value read returns present pin level, whatever its configuration
// - general-purpose output pin drives its held pin value
// - input pin: write leaves pin level alone, read returns sensed level
// - alternate-function pin: write has no effect, read shows that function's level
// - switching to output first drives the last sensed level
// - every pin can raise an edge- or level-sensitive interrupt
// - edge interrupt on rising, falling or both edges
// - level interrupt active high or active low
// - read-only raw flags show met trigger conditions before masking
// - read-only masked flags show interrupt state after masking
// - write-only clear register clears pending edge detection per pin
// - each of four ports decodes its own 64 KB window, 0x10000 apart
// - sense bit 0 selects edge detection, 1 level detection
// - dual-edge bit 1 fires on both edges, else polarity chooses edge
// - polarity 0 falling or low, 1 rising or high
// - mask bit 1 lets the pin reach its own and the combined line
`timescale 1ns/100ps
module gpd_port #(
    parameter int PORT_INDEX = 0,               // which of the four windows this port decodes
    parameter logic [11:0] PIN_PRESENT = 12'hfff // pins bonded out on this part
)(
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic clk_en,
    input wire gpd_pkg::gpd_bus_req_t bus_req,
    output logic [gpd_pkg::DATA_W-1:0] bus_rdata,
    output logic bus_ack,
    input wire logic [gpd_pkg::PIN_COUNT-1:0] pin_in,
    output logic [gpd_pkg::PIN_COUNT-1:0] pin_out,
    output logic [gpd_pkg::PIN_COUNT-1:0] pin_oe,
    input wire logic [gpd_pkg::PIN_COUNT-1:0] alt_sel,
    input wire logic [gpd_pkg::PIN_COUNT-1:0] alt_out,
    input wire logic [gpd_pkg::PIN_COUNT-1:0] alt_oe,
    output logic [gpd_pkg::PIN_COUNT-1:0] pin_irq,
    output logic port_irq
);

    localparam int NP = gpd_pkg::PIN_COUNT;
    localparam int OW = gpd_pkg::OFFS_W;
    localparam int AW = gpd_pkg::ADDR_W;
    localparam int DW = gpd_pkg::DATA_W;
    localparam int HW = gpd_pkg::HALF_W;

    // window base of this port
    localparam logic [AW-1:0] MY_BASE =
        gpd_pkg::PORT_BASE0 + gpd_pkg::PORT_STRIDE * AW'(PORT_INDEX);

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    logic [NP-1:0] pin_value_r;
    logic [NP-1:0] pin_direction_r;
    logic [NP-1:0] irq_sense_select_r;
    logic [NP-1:0] irq_dual_edge_r;
    logic [NP-1:0] irq_polarity_r;
    logic [NP-1:0] irq_mask_r;
    logic [DW-1:0] rdata_r;
    logic ack_r;
    logic [NP-1:0] pin_out_r;
    logic [NP-1:0] pin_oe_r;
    logic [NP-1:0] pin_irq_r;
    logic port_irq_r;

    // ------------------------------------------------------------------
    // decode
    // ------------------------------------------------------------------
    logic [NP-1:0] pin_sync;
    logic [NP-1:0] irq_raw_flags;
    logic [NP-1:0] irq_masked_flags;
    logic [NP-1:0] edge_clear;
    logic [NP-1:0] wr_bits;
    logic [NP-1:0] addr_mask;
    logic [NP-1:0] gpio_out;
    logic [OW-1:0] offs;
    logic hit;
    logic wr_en;
    logic rd_en;
    logic in_value_win;
    logic [DW-1:0] rd_word;

    // this port answers only inside its own 64 KB window
    assign hit = bus_req.sel && (bus_req.addr[AW-1:OW] == MY_BASE[AW-1:OW]);
    assign offs = bus_req.addr[OW-1:0];
    assign wr_en = hit && bus_req.write;
    assign rd_en = hit && !bus_req.write;

    // word or half-word: both carry the 12 pin bits in the low half
    assign wr_bits = bus_req.wdata[NP-1:0] & PIN_PRESENT;

    // address bits 13..2 select which pin bits a value access touches
    assign in_value_win = (offs < gpd_pkg::OFS_PIN_VALUE_END);
    assign addr_mask = offs[gpd_pkg::MASK_LSB+NP-1:gpd_pkg::MASK_LSB];

    // pin driven by the value register: output direction and not handed to another function
    assign gpio_out = pin_direction_r & ~alt_sel;

    // ------------------------------------------------------------------
    // pin input synchroniser
    // ------------------------------------------------------------------
    gpd_sync2 #(
        .WIDTH(NP)
    ) u_sync (
        .ref_clk(ref_clk),
        .resetn(resetn),
        .clk_en(clk_en),
        .async_in(pin_in),
        .sync_out(pin_sync)
    );

    // ------------------------------------------------------------------
    // per-pin interrupt detection
    // ------------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < NP; gi++)
        begin : g_pin
            gpd_pkg::gpd_irq_cfg_t cfg;

            assign cfg.sense = irq_sense_select_r[gi];
            assign cfg.dual = irq_dual_edge_r[gi];
            assign cfg.pol = irq_polarity_r[gi];

            gpd_irq_cell u_cell (
                .ref_clk(ref_clk),
                .resetn(resetn),
                .clk_en(clk_en),
                .level(pin_sync[gi]),
                .cfg(cfg),
                .edge_clear(edge_clear[gi]),
                .raw_flag(irq_raw_flags[gi])
            );
        end
    endgenerate

    // clear strobe for edge flags; level pins ignore it inside the cell
    assign edge_clear = (wr_en && offs == gpd_pkg::OFS_IRQ_EDGE_CLEAR) ?
                        wr_bits : gpd_pkg::RST_PINS;

    // mask gates raw flags
    assign irq_masked_flags = irq_raw_flags & irq_mask_r & PIN_PRESENT;

    // ------------------------------------------------------------------
    // pin value register
    // ------------------------------------------------------------------

    // output pins take written bits; other pins keep mirroring the sensed level
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
            pin_value_r <= gpd_pkg::RST_PINS;
        else if (clk_en)
        begin
            for (int k = 0; k < NP; k++)
            begin
                if (!gpio_out[k])
                    pin_value_r[k] <= pin_sync[k];
                else if (wr_en && in_value_win && addr_mask[k] && PIN_PRESENT[k])
                    pin_value_r[k] <= wr_bits[k];
            end
        end
    end

    // ------------------------------------------------------------------
    // direction register
    // ------------------------------------------------------------------

    // all pins come up as inputs
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
            pin_direction_r <= gpd_pkg::RST_PINS;
        else if (clk_en && wr_en && offs == gpd_pkg::OFS_PIN_DIRECTION)
            pin_direction_r <= wr_bits;
    end

    // ------------------------------------------------------------------
    // interrupt configuration registers
    // ------------------------------------------------------------------

    // sense select
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
            irq_sense_select_r <= gpd_pkg::RST_PINS;
        else if (clk_en && wr_en && offs == gpd_pkg::OFS_IRQ_SENSE_SELECT)
            irq_sense_select_r <= wr_bits;
    end

    // dual edge
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
            irq_dual_edge_r <= gpd_pkg::RST_PINS;
        else if (clk_en && wr_en && offs == gpd_pkg::OFS_IRQ_DUAL_EDGE)
            irq_dual_edge_r <= wr_bits;
    end

    // polarity
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
            irq_polarity_r <= gpd_pkg::RST_PINS;
        else if (clk_en && wr_en && offs == gpd_pkg::OFS_IRQ_POLARITY)
            irq_polarity_r <= wr_bits;
    end

    // mask
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
            irq_mask_r <= gpd_pkg::RST_PINS;
        else if (clk_en && wr_en && offs == gpd_pkg::OFS_IRQ_MASK)
            irq_mask_r <= wr_bits;
    end

    // ------------------------------------------------------------------
    // read multiplexer
    // ------------------------------------------------------------------

    // unmapped and write-only offsets read as zero; reserved bits read zero
    always_comb
    begin
        rd_word = gpd_pkg::RST_WORD;
        if (in_value_win)
            rd_word[NP-1:0] = pin_sync & addr_mask & PIN_PRESENT;
        else
        begin
            case (offs)
                gpd_pkg::OFS_PIN_DIRECTION:
                    rd_word[NP-1:0] = pin_direction_r;
                gpd_pkg::OFS_IRQ_SENSE_SELECT:
                    rd_word[NP-1:0] = irq_sense_select_r;
                gpd_pkg::OFS_IRQ_DUAL_EDGE:
                    rd_word[NP-1:0] = irq_dual_edge_r;
                gpd_pkg::OFS_IRQ_POLARITY:
                    rd_word[NP-1:0] = irq_polarity_r;
                gpd_pkg::OFS_IRQ_MASK:
                    rd_word[NP-1:0] = irq_mask_r;
                gpd_pkg::OFS_IRQ_RAW_FLAGS:
                    rd_word[NP-1:0] = irq_raw_flags & PIN_PRESENT;
                gpd_pkg::OFS_IRQ_MASKED_FLAGS:
                    rd_word[NP-1:0] = irq_masked_flags;
                default:
                    rd_word = gpd_pkg::RST_WORD;
            endcase
        end
        if (bus_req.half)
            rd_word[DW-1:HW] = '0;
    end

    // ------------------------------------------------------------------
    // bus answer
    // ------------------------------------------------------------------

    // read data captured with the request, ack one cycle later
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
            rdata_r <= gpd_pkg::RST_WORD;
        else if (clk_en && rd_en)
            rdata_r <= rd_word;
    end

    // one-cycle acknowledge for every access to this window made while clk_en is high
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
            ack_r <= 1'b0;
        else if (clk_en)
            ack_r <= hit;
    end

    assign bus_rdata = rdata_r;
    assign bus_ack = ack_r;

    // ------------------------------------------------------------------
    // pad drive
    // ------------------------------------------------------------------

    // gpio output pins drive the value register, other-function pins their own drive
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            pin_out_r <= gpd_pkg::RST_PINS;
            pin_oe_r <= gpd_pkg::RST_PINS;
        end
        else if (clk_en)
        begin
            pin_out_r <= ((pin_value_r & gpio_out) | (alt_out & alt_sel)) & PIN_PRESENT;
            pin_oe_r <= (gpio_out | (alt_oe & alt_sel)) & PIN_PRESENT;
        end
    end

    assign pin_out = pin_out_r;
    assign pin_oe = pin_oe_r;

    // ------------------------------------------------------------------
    // interrupt lines
    // ------------------------------------------------------------------

    // masked flags reach per-pin lines and the combined port line
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            pin_irq_r <= gpd_pkg::RST_PINS;
            port_irq_r <= 1'b0;
        end
        else if (clk_en)
        begin
            pin_irq_r <= irq_masked_flags;
            port_irq_r <= |irq_masked_flags;
        end
    end

    assign pin_irq = pin_irq_r;
    assign port_irq = port_irq_r;

endmodule

/* test/gpd_pin_board.sv */
// gpd_pin_board: board-side model of the twelve port pads
// assumes: pads have pull-ups; a pad driven from both sides reads unknown
`timescale 1ns/100ps
module gpd_pin_board (
    input wire logic [11:0] pin_out,
    input wire logic [11:0] pin_oe,
    input wire logic [11:0] drv_val,
    input wire logic [11:0] drv_en,
    output logic [11:0] pin_in
);
    // resolve each pad: contention, port drive, board drive, else pull-up
    always_comb
    begin
        for (int i = 0; i < 12; i++)
            pin_in[i] = (pin_oe[i] && drv_en[i]) ? 1'bx :
                pin_oe[i] ? pin_out[i] : drv_en[i] ? drv_val[i] : 1'b1;
    end
endmodule

/* test/gpd_port_chk.sv */
// gpd_port_chk: concurrent checks on the ports of gpd_port
// assumes: bound to every gpd_port; clk_en is held high by the bench except for one bus request in t_freeze
`timescale 1ns/100ps
module gpd_port_chk #(
    parameter int PORT_INDEX = 0,
    parameter logic [11:0] PIN_PRESENT = 12'hfff
)(
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic clk_en,
    input wire gpd_pkg::gpd_bus_req_t bus_req,
    input wire logic [gpd_pkg::DATA_W-1:0] bus_rdata,
    input wire logic bus_ack,
    input wire logic [gpd_pkg::PIN_COUNT-1:0] pin_in,
    input wire logic [gpd_pkg::PIN_COUNT-1:0] pin_out,
    input wire logic [gpd_pkg::PIN_COUNT-1:0] pin_oe,
    input wire logic [gpd_pkg::PIN_COUNT-1:0] alt_sel,
    input wire logic [gpd_pkg::PIN_COUNT-1:0] alt_out,
    input wire logic [gpd_pkg::PIN_COUNT-1:0] alt_oe,
    input wire logic [gpd_pkg::PIN_COUNT-1:0] pin_irq,
    input wire logic port_irq
);
    // ------------------------------------------------------------------
    // request decode and irq mask shadow
    // ------------------------------------------------------------------
    logic hit;
    logic [11:0] mask_q;
    logic [11:0] mask_p;
    assign hit = clk_en && bus_req.sel && (bus_req.addr[31:16] == 16'h5000 + 16'(PORT_INDEX));
    // shadow follows the mask register edge for edge, plus one stage of lag
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            mask_q <= 12'h000;
            mask_p <= 12'h000;
        end
        else
        begin
            if (hit && bus_req.write && bus_req.addr[15:0] == gpd_pkg::OFS_IRQ_MASK)
                mask_q <= bus_req.wdata[11:0] & PIN_PRESENT;
            mask_p <= mask_q;
        end
    end
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!resetn);
    // ------------------------------------------------------------------
    // port checks
    // ------------------------------------------------------------------
    AST_ACK_HIT: assert property (hit |=> bus_ack)
        else $error("no ack one cycle after a hit");
    AST_ACK_CAUSE: assert property (bus_ack |-> $past(hit))
        else $error("ack without a hit");
    AST_OE_RESET: assert property ($rose(resetn) |-> pin_oe == 12'h000)
        else $error("pin enabled right after reset");
    AST_DIR_OE: assert property (hit && bus_req.write && alt_sel == 12'h000 &&
        bus_req.addr[15:0] == gpd_pkg::OFS_PIN_DIRECTION ##1 alt_sel == 12'h000
        |-> ##2 pin_oe == $past(bus_req.wdata[11:0], 3))
        else $error("pin enable differs from direction written");
    AST_ALT_MIRROR: assert property ($past(resetn) && $past(clk_en) |->
        (pin_out & $past(alt_sel)) == $past(alt_out & alt_sel) &&
        (pin_oe & $past(alt_sel)) == $past(alt_oe & alt_sel))
        else $error("other function drive not mirrored");
    AST_PORT_OR: assert property (port_irq == (|pin_irq))
        else $error("combined irq differs from pin irqs");
    AST_MASK_BLOCK: assert property ((pin_irq & ~mask_q & ~mask_p) == 12'h000)
        else $error("masked pin raised its irq");
    AST_RDATA_RESV: assert property (bus_ack && !$past(bus_req.write)
        |-> bus_rdata[31:12] == 20'h0_0000)
        else $error("reserved read bits not zero");
    AST_RDATA_HOLD: assert property ($changed(bus_rdata) |-> bus_ack)
        else $error("read data changed without an ack");
endmodule
bind gpd_port gpd_port_chk #(.PORT_INDEX(PORT_INDEX), .PIN_PRESENT(PIN_PRESENT)) i_gpd_port_chk (
    .ref_clk(ref_clk), .resetn(resetn), .clk_en(clk_en), .bus_req(bus_req),
    .bus_rdata(bus_rdata), .bus_ack(bus_ack), .pin_in(pin_in), .pin_out(pin_out),
    .pin_oe(pin_oe), .alt_sel(alt_sel), .alt_out(alt_out), .alt_oe(alt_oe),
    .pin_irq(pin_irq), .port_irq(port_irq));

/* test/tb.sv */
// tb: self-checking bench for gpd_port placed as the second port
// assumes: gpd_pin_board stands on the pads; checker is bound separately
`timescale 1ns/100ps
module tb;
    localparam logic [31:0] BASE = gpd_pkg::PORT_BASE0 + gpd_pkg::PORT_STRIDE;
    logic ref_clk, resetn, clk_en, ack, port_irq;
    gpd_pkg::gpd_bus_req_t req;
    logic [31:0] rdata;
    logic [11:0] pin_in, pin_out, pin_oe, alt_sel, alt_out, alt_oe, pin_irq, drv_val, drv_en;
    int fail_count = 0;
    int cmp_count = 0;
    gpd_port #(.PORT_INDEX(1), .PIN_PRESENT(12'hfff)) i_gpd_port (
        .ref_clk(ref_clk), .resetn(resetn), .clk_en(clk_en), .bus_req(req),
        .bus_rdata(rdata), .bus_ack(ack), .pin_in(pin_in), .pin_out(pin_out),
        .pin_oe(pin_oe), .alt_sel(alt_sel), .alt_out(alt_out), .alt_oe(alt_oe),
        .pin_irq(pin_irq), .port_irq(port_irq));
    gpd_pin_board i_gpd_pin_board (.pin_out(pin_out), .pin_oe(pin_oe),
        .drv_val(drv_val), .drv_en(drv_en), .pin_in(pin_in));
    // ------------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------------
    task automatic complete_run();
        if (fail_count == 0 && cmp_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e)
        begin
            fail_count++;
            $display("unexpected %s: expected %h, seen %h", n, e, g);
        end
    endtask
    // one request, taken at the next edge, answer checked one cycle later
    task automatic bus(input logic w, input logic h, input logic [31:0] a,
        input logic [31:0] d, input logic ak, output logic [31:0] r);
        @(posedge ref_clk);
        #1;
        req = '{sel: 1'b1, write: w, half: h, addr: a, wdata: d};
        @(posedge ref_clk);
        #1;
        req.sel = 1'b0;
        chk("bus_ack", 32'(ak), 32'(ack));
        r = rdata;
    endtask
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        logic [31:0] r;
        bus(1'b1, 1'b0, BASE + a, d, 1'b1, r);
    endtask
    task automatic rd(input string n, input logic [31:0] a, input logic [31:0] e);
        logic [31:0] r;
        bus(1'b0, 1'b0, BASE + a, 32'h0000_0000, 1'b1, r);
        chk(n, e, r);
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    // ------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------
    task automatic t_reset();
        logic [31:0] r;
        for (int o = 'h8000; o <= 'h801c; o += 4)
            rd("reset_value", 32'(o), 32'h0000_0000);
        rd("unmapped", 32'h0000_4000, 32'h0000_0000);
        bus(1'b0, 1'b0, gpd_pkg::PORT_BASE0 + 32'h0000_8000, 32'h0, 1'b0, r);
    endtask
    task automatic t_regs();
        logic [31:0] r;
        for (int o = 'h8004; o <= 'h8010; o += 4)
        begin
            wr(32'(o), 32'hffff_ffff);
            rd("reg_rw", 32'(o), 32'h0000_0fff);
            wr(32'(o), 32'h0000_0000);
        end
        bus(1'b1, 1'b1, BASE + 32'h0000_8008, 32'h0000_0a5a, 1'b1, r);
        bus(1'b0, 1'b1, BASE + 32'h0000_8008, 32'h0000_0000, 1'b1, r);
        chk("half_read", 32'h0000_0a5a, r);
        wr(32'h0000_8008, 32'h0000_0000);
    endtask
    // pin 0 through each trigger mode: rise, fall, both, high, low
    task automatic t_irq();
        logic [2:0] cfg [5] = '{3'b001, 3'b000, 3'b010, 3'b101, 3'b100};
        logic [3:0] ex [5] = '{4'b0010, 4'b1000, 4'b1010, 4'b0110, 4'b1001};
        for (int m = 0; m < 5; m++)
        begin
            wr(32'h0000_8004, 32'(cfg[m][2]));
            wr(32'h0000_8008, 32'(cfg[m][1]));
            wr(32'h0000_800c, 32'(cfg[m][0]));
            wr(32'h0000_8010, 32'h0000_0001);
            wr(32'h0000_801c, 32'h0000_0fff);
            rd("raw_low", 32'h0000_8014, 32'(ex[m][0]));
            drv_val = 12'h001;
            cyc(5);
            rd("raw_rise", 32'h0000_8014, 32'(ex[m][1]));
            wr(32'h0000_801c, 32'h0000_0001);
            rd("raw_cleared", 32'h0000_8014, 32'(ex[m][2]));
            drv_val = 12'h000;
            cyc(5);
            rd("raw_fall", 32'h0000_8014, 32'(ex[m][3]));
            rd("masked", 32'h0000_8018, 32'(ex[m][3]));
            chk("port_irq", 32'(ex[m][3]), 32'(port_irq));
            chk("pin_irq", 32'(ex[m][3]), 32'(pin_irq));
            wr(32'h0000_8010, 32'h0000_0000);
            cyc(2);
            rd("masked_off", 32'h0000_8018, 32'h0000_0000);
            chk("port_irq_off", 32'h0000_0000, 32'(port_irq));
        end
    endtask
    task automatic t_pins();
        drv_val = 12'ha5c;
        cyc(3);
        wr(32'h0000_3ffc, 32'h0000_0fff);
        rd("pin_read", 32'h0000_3ffc, 32'h0000_0a5c);
        rd("masked_read", 32'h0000_03c0, 32'h0000_0050);
        wr(32'h0000_8000, 32'h0000_0fff);
        drv_en = 12'h000;
        cyc(2);
        chk("pin_oe", 32'h0000_0fff, 32'(pin_oe));
        chk("pin_out_hold", 32'h0000_0a5c, 32'(pin_out));
        wr(32'h0000_003c, 32'h0000_0000);
        cyc(1);
        chk("masked_write", 32'h0000_0a50, 32'(pin_out));
        wr(32'h0000_3ffc, 32'h0000_0123);
        cyc(1);
        chk("pin_out", 32'h0000_0123, 32'(pin_out));
        cyc(2);
        rd("out_read", 32'h0000_3ffc, 32'h0000_0123);
    endtask
    task automatic t_alt();
        alt_out = 12'h005;
        alt_oe = 12'h00f;
        alt_sel = 12'h00f;
        wr(32'h0000_3ffc, 32'h0000_0fff);
        cyc(1);
        chk("alt_drive", 32'h0000_0ff5, 32'(pin_out));
        cyc(2);
        rd("alt_out_read", 32'h0000_3ffc, 32'h0000_0ff5);
        alt_oe = 12'h000;
        cyc(1);
        drv_val = 12'h00a;
        drv_en = 12'h00f;
        cyc(3);
        rd("alt_in_read", 32'h0000_3ffc, 32'h0000_0ffa);
    endtask
    task automatic t_freeze();
        logic [31:0] r;
        cyc(1);
        clk_en = 1'b0;
        bus(1'b1, 1'b0, BASE + 32'h0000_8000, 32'h0000_0000, 1'b0, r);
        clk_en = 1'b1;
        rd("dir_frozen", 32'h0000_8000, 32'h0000_0fff);
    endtask
    // ------------------------------------------------------------------
    // clock, sequence and watchdog
    // ------------------------------------------------------------------
    initial
    begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end
    initial
    begin
        resetn = 1'b0;
        clk_en = 1'b1;
        req = '0;
        drv_val = 12'h000;
        drv_en = 12'hfff;
        alt_sel = 12'h000;
        alt_out = 12'h000;
        alt_oe = 12'h000;
        repeat (6) @(posedge ref_clk);
        #1;
        resetn = 1'b1;
        t_reset();
        t_regs();
        t_irq();
        t_pins();
        t_alt();
        t_freeze();
        complete_run();
    end
    // the sequence needs under 1,500 cycles
    initial
    begin
        repeat (20000) @(posedge ref_clk);
        fail_count++;
        complete_run();
    end
endmodule
